// ==== logic/flow_io_pkg.sv ====
// Constants, register map and function codes for the flow meter I/O logic
package flow_io_pkg;
    localparam int AW = 8;
    localparam int DW = 32;
    localparam int ST_W = 5;

    // Register offsets
    localparam logic [7:0] REG_CFG = 8'h00;
    localparam logic [7:0] REG_PULSE = 8'h04;
    localparam logic [7:0] REG_CREEP = 8'h08;
    localparam logic [7:0] REG_LIM_LO = 8'h0C;
    localparam logic [7:0] REG_LIM_HI = 8'h10;
    localparam logic [7:0] REG_GAIN = 8'h14;
    localparam logic [7:0] REG_TOTAL = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1C;
    localparam logic [7:0] REG_MASK = 8'h20;
    localparam logic [7:0] REG_STATE = 8'h24;

    // Configuration field positions
    localparam int CFG_Q1_FN = 0;
    localparam int CFG_Q1_POL = 3;
    localparam int CFG_Q2_FN = 4;
    localparam int CFG_Q2_POL = 7;
    localparam int CFG_IN_FN = 8;
    localparam int CFG_AOUT_0_20 = 10;
    localparam int CFG_AOUT_EN = 11;
    localparam logic [31:0] CFG_RESET = 32'h0000_0898;

    // Status bit positions
    localparam int ST_DOSE = 0;
    localparam int ST_OFFSET = 1;
    localparam int ST_CLEAR = 2;
    localparam int ST_LIMIT = 3;
    localparam int ST_EMPTY = 4;

    // Pulse value in 0.1 ml, flow in 0.006 l/min, current in uA
    localparam logic [15:0] PULSE_MIN = 16'h0001;
    localparam logic [15:0] PULSE_MAX = 16'h7530;
    localparam logic [15:0] PULSE_RESET = 16'h000A;
    localparam logic [15:0] CREEP_RESET = 16'h0004;
    localparam logic [15:0] LIM_LO_RESET = 16'h0000;
    localparam logic [15:0] LIM_HI_RESET = 16'h1770;
    localparam logic [15:0] GAIN_RESET = 16'h02AB;
    localparam int GAIN_SHIFT = 8;
    localparam logic [15:0] UA_0 = 16'h0000;
    localparam logic [15:0] UA_4 = 16'h0FA0;
    localparam logic [15:0] UA_20 = 16'h4E20;
    localparam logic [15:0] UA_ALERT = 16'h0DAC;

    // Switched output pulse width
    localparam int CLK_MHZ = 100;
    localparam int PULSE_TIME_US = 1000;
    localparam int PULSE_CYCLES = PULSE_TIME_US * CLK_MHZ;

    typedef enum logic [2:0] {
        FN_PULSE, FN_EMPTY, FN_DOSING, FN_LIMIT, FN_REVERSE, FN_OFF
    } out_fn_t;

    typedef enum logic [1:0] {
        IN_DOSE, IN_OFFSET, IN_CLEAR, IN_CREEP
    } in_fn_t;
endpackage

// ==== logic/ctl_input_cond.sv ====
// Control input synchroniser and rising edge detector
`timescale 1ns/100ps
module ctl_input_cond (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Pin and conditioned result
    input wire logic pin_i,
    output logic level_o,
    output logic rise_o
);
    logic sync1_r, sync2_r, prev_r;
    logic sync1_nxt, sync2_nxt, prev_nxt;

    always_comb begin
        sync1_nxt = pin_i;
        sync2_nxt = sync1_r;
        prev_nxt = sync2_r;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            prev_r <= 1'b0;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            prev_r <= prev_nxt;
        end
    end

    assign level_o = sync2_r;
    assign rise_o = sync2_r & ~prev_r;

    // One transition, one trigger
    chk_rise_once: assert property (@(posedge clock) disable iff (!resetn)
        rise_o |=> !rise_o) else $error("edge seen twice");
endmodule // ctl_input_cond

// ==== logic/vol_pulse.sv ====
// Volume scaled pulse generator with owed pulse counter
`timescale 1ns/100ps
module vol_pulse #(
    parameter int WIDTH_CYC = flow_io_pkg::PULSE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Volume increments
    input wire logic enable,
    input wire logic inc_valid,
    input wire logic [15:0] inc,
    input wire logic [15:0] pulse_val,
    // Pulse out
    output logic pulse_o
);
    typedef enum logic [1:0] {P_IDLE, P_HIGH, P_LOW} pstate_t;
    pstate_t state_r, state_nxt;
    logic [16:0] acc_r, acc_nxt;
    logic [7:0] owed_r, owed_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic [16:0] sum;
    logic fire, start;

    always_comb begin
        sum = acc_r + {1'b0, inc};
        fire = enable && inc_valid && sum >= {1'b0, pulse_val};
        start = state_r == P_IDLE && owed_r != 8'h00;
        acc_nxt = acc_r;
        if (enable && inc_valid)
            acc_nxt = fire ? sum - {1'b0, pulse_val} : sum;
        owed_nxt = owed_r;
        // Saturate rather than wrap when pulses outrun the width
        if (fire && !start && owed_r != 8'hFF)
            owed_nxt = owed_r + 8'h01;
        else if (start && !fire)
            owed_nxt = owed_r - 8'h01;
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        unique case (state_r)
            P_IDLE: if (start) begin
                state_nxt = P_HIGH;
                cnt_nxt = 32'(WIDTH_CYC - 1);
            end
            P_HIGH: if (cnt_r == 32'h0) begin
                state_nxt = P_LOW;
                cnt_nxt = 32'(WIDTH_CYC - 1);
            end else begin
                cnt_nxt = cnt_r - 32'h1;
            end
            P_LOW: if (cnt_r == 32'h0) begin
                state_nxt = P_IDLE;
            end else begin
                cnt_nxt = cnt_r - 32'h1;
            end
            default: state_nxt = P_IDLE;
        endcase
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= P_IDLE;
            acc_r <= 17'h00000;
            owed_r <= 8'h00;
            cnt_r <= 32'h0;
        end else begin
            state_r <= state_nxt;
            acc_r <= acc_nxt;
            owed_r <= owed_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign pulse_o = state_r == P_HIGH;

    chk_pulse_owed: assert property (@(posedge clock) disable iff (!resetn)
        $rose(pulse_o) |-> $past(owed_r) != 8'h00)
        else $error("pulse without owed volume");
    chk_pulse_hold: assert property (@(posedge clock) disable iff (!resetn)
        pulse_o && cnt_r != 32'h0 |=> pulse_o)
        else $error("pulse cut short");
endmodule // vol_pulse

// ==== logic/flow_io_top.sv ====
// Switched outputs, control input and current loop logic of the meter
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module flow_io_top #(
    parameter int PULSE_CYC = flow_io_pkg::PULSE_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Register port
    input wire logic [flow_io_pkg::AW-1:0] reg_addr,
    input wire logic [flow_io_pkg::DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [flow_io_pkg::DW-1:0] reg_rdata,
    // Measurement results
    input wire logic flow_valid,
    input wire logic signed [15:0] flow_rate,
    input wire logic [15:0] vol_inc,
    input wire logic empty_pipe,
    input wire logic dosing_active,
    // Actions to measurement and dosing logic
    output logic dose_start,
    output logic offset_capture,
    output logic creep_disabled,
    // Pins
    input wire logic control_input,
    output logic primary_switch_output,
    output logic secondary_switch_output,
    output logic [15:0] current_loop_output,
    // Interrupt
    output logic irq
);
    import flow_io_pkg::*;

    function automatic logic fn_level(input logic [2:0] fn, input logic pol,
            input logic pls, input logic emp, input logic dos,
            input logic lim, input logic rev);
        logic act;
        act = 1'b0;
        case (fn)
            FN_PULSE: act = pls;
            FN_EMPTY: act = emp;
            FN_DOSING: act = dos;
            FN_LIMIT: act = lim;
            FN_REVERSE: act = rev;
            default: act = 1'b0;
        endcase
        // High level stands for 24 V at the pin
        return pol ? act : ~act;
    endfunction

    // Register file
    logic [31:0] cfg_r, cfg_nxt;
    logic [15:0] pval_r, pval_nxt;
    logic [15:0] creep_r, creep_nxt;
    logic signed [15:0] lo_r, lo_nxt, hi_r, hi_nxt;
    logic [15:0] gain_r, gain_nxt;
    logic [ST_W-1:0] st_r, st_nxt, mask_r, mask_nxt;
    logic [ST_W-1:0] ev;
    logic wr_status, wr_total;

    // Measurement state
    logic signed [15:0] flow_r, flow_nxt;
    logic empty_r, empty_nxt, dosing_r, dosing_nxt;
    logic supp_r, supp_nxt, lim_r, lim_nxt;
    logic [31:0] tot_r, tot_nxt;
    logic dose_r, dose_nxt, offs_r, offs_nxt, cdis_r, cdis_nxt;
    logic inc_vld_r, inc_vld_nxt;
    logic [15:0] inc_r, inc_nxt;

    // Output state
    logic q1_r, q1_nxt, q2_r, q2_nxt;
    logic [15:0] aout_r, aout_nxt;
    logic [31:0] rdata_r, rdata_nxt;

    logic ctl_level, ctl_rise, vpulse;
    logic [2:0] q1_fn, q2_fn;
    logic q1_pol, q2_pol;
    in_fn_t in_fn;
    logic [16:0] flow_abs, creep_low;
    logic limit_hit, rev;
    logic clr_evt, creep_dis;

    assign q1_fn = cfg_r[CFG_Q1_FN +: 3];
    assign q2_fn = cfg_r[CFG_Q2_FN +: 3];
    assign q1_pol = cfg_r[CFG_Q1_POL];
    assign q2_pol = cfg_r[CFG_Q2_POL];
    assign in_fn = in_fn_t'(cfg_r[CFG_IN_FN +: 2]);

    ctl_input_cond u_in (
        .clock(clock),
        .resetn(resetn),
        .pin_i(control_input),
        .level_o(ctl_level),
        .rise_o(ctl_rise)
    );

    // One generator feeds both outputs, so both share the pulse value
    vol_pulse #(.WIDTH_CYC(PULSE_CYC)) u_pulse (
        .clock(clock),
        .resetn(resetn),
        .enable(1'b1),
        .inc_valid(inc_vld_r),
        .inc(inc_r),
        .pulse_val(pval_r),
        .pulse_o(vpulse)
    );

    // Register writes; hardware set wins over write-one clear
    always_comb begin
        wr_status = reg_wr && reg_addr == REG_STATUS;
        wr_total = reg_wr && reg_addr == REG_TOTAL;
        cfg_nxt = cfg_r;
        pval_nxt = pval_r;
        creep_nxt = creep_r;
        lo_nxt = lo_r;
        hi_nxt = hi_r;
        gain_nxt = gain_r;
        mask_nxt = mask_r;
        if (reg_wr) begin
            unique case (reg_addr)
                REG_CFG: cfg_nxt = {20'h00000, reg_wdata[11:0]};
                REG_PULSE: begin
                    // Clamp to the 0.1 to 3000 ml range
                    if (reg_wdata[15:0] < PULSE_MIN)
                        pval_nxt = PULSE_MIN;
                    else if (reg_wdata[15:0] > PULSE_MAX)
                        pval_nxt = PULSE_MAX;
                    else
                        pval_nxt = reg_wdata[15:0];
                end
                REG_CREEP: creep_nxt = reg_wdata[15:0];
                REG_LIM_LO: lo_nxt = reg_wdata[15:0];
                REG_LIM_HI: hi_nxt = reg_wdata[15:0];
                REG_GAIN: gain_nxt = reg_wdata[15:0];
                REG_MASK: mask_nxt = reg_wdata[ST_W-1:0];
                default: ;
            endcase
        end
        st_nxt = (st_r & ~(wr_status ? reg_wdata[ST_W-1:0] : '0)) | ev;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cfg_r <= CFG_RESET;
            pval_r <= PULSE_RESET;
            creep_r <= CREEP_RESET;
            lo_r <= LIM_LO_RESET;
            hi_r <= LIM_HI_RESET;
            gain_r <= GAIN_RESET;
            mask_r <= '0;
            st_r <= '0;
        end else begin
            cfg_r <= cfg_nxt;
            pval_r <= pval_nxt;
            creep_r <= creep_nxt;
            lo_r <= lo_nxt;
            hi_r <= hi_nxt;
            gain_r <= gain_nxt;
            mask_r <= mask_nxt;
            st_r <= st_nxt;
        end
    end

    // Measurement processing
    always_comb begin
        flow_abs = flow_r[15] ? 17'(-{flow_r[15], flow_r})
                              : {1'b0, flow_r};
        creep_low = {1'b0, creep_r} - {3'b000, creep_r[15:2]};
        limit_hit = flow_r >= hi_r || flow_r <= lo_r;
        rev = flow_r[15];
        creep_dis = in_fn == IN_CREEP && ctl_level;
        clr_evt = (in_fn == IN_CLEAR && ctl_rise) || wr_total;
        flow_nxt = flow_valid ? flow_rate : flow_r;
        empty_nxt = empty_pipe;
        dosing_nxt = dosing_active;
        lim_nxt = limit_hit;
        supp_nxt = supp_r;
        if (creep_dis)
            supp_nxt = 1'b0;
        else if (flow_abs < creep_low)
            supp_nxt = 1'b1;
        else if (flow_abs > {1'b0, creep_r})
            supp_nxt = 1'b0;
        // Reverse flow and suppressed flow add no volume
        inc_vld_nxt = flow_valid && !supp_r && !flow_rate[15];
        inc_nxt = vol_inc;
        tot_nxt = tot_r;
        if (clr_evt)
            tot_nxt = 32'h0;
        else if (inc_vld_r)
            tot_nxt = tot_r + {16'h0000, inc_r};
        dose_nxt = in_fn == IN_DOSE && ctl_rise;
        offs_nxt = in_fn == IN_OFFSET && ctl_rise;
        cdis_nxt = creep_dis;
        ev = '0;
        ev[ST_DOSE] = dose_nxt;
        ev[ST_OFFSET] = offs_nxt;
        ev[ST_CLEAR] = clr_evt;
        ev[ST_LIMIT] = limit_hit && !lim_r;
        ev[ST_EMPTY] = empty_pipe && !empty_r;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            flow_r <= 16'sh0000;
            empty_r <= 1'b0;
            dosing_r <= 1'b0;
            lim_r <= 1'b0;
            supp_r <= 1'b0;
            inc_vld_r <= 1'b0;
            inc_r <= 16'h0000;
            tot_r <= 32'h0;
            dose_r <= 1'b0;
            offs_r <= 1'b0;
            cdis_r <= 1'b0;
        end else begin
            flow_r <= flow_nxt;
            empty_r <= empty_nxt;
            dosing_r <= dosing_nxt;
            lim_r <= lim_nxt;
            supp_r <= supp_nxt;
            inc_vld_r <= inc_vld_nxt;
            inc_r <= inc_nxt;
            tot_r <= tot_nxt;
            dose_r <= dose_nxt;
            offs_r <= offs_nxt;
            cdis_r <= cdis_nxt;
        end
    end

    // Pins, current loop and read data
    always_comb begin
        logic signed [16:0] diff;
        logic signed [33:0] scaled;
        logic [15:0] base;
        diff = 17'sh00000;
        scaled = 34'sh0;
        base = cfg_r[CFG_AOUT_0_20] ? UA_0 : UA_4;
        q1_nxt = fn_level(q1_fn, q1_pol, vpulse, empty_r, dosing_r,
                          limit_hit, rev);
        q2_nxt = fn_level(q2_fn, q2_pol, vpulse, empty_r, dosing_r,
                          limit_hit, rev);
        diff = {flow_r[15], flow_r} - {lo_r[15], lo_r};
        scaled = (diff * $signed({1'b0, gain_r})) >>> GAIN_SHIFT;
        if (!cfg_r[CFG_AOUT_EN])
            aout_nxt = UA_0;
        else if (!cfg_r[CFG_AOUT_0_20] && empty_r)
            aout_nxt = UA_ALERT;
        else if (supp_r || scaled < 34'sh0)
            aout_nxt = base;
        else if (scaled > $signed({18'h00000, UA_20 - base}))
            aout_nxt = UA_20;
        else
            aout_nxt = base + scaled[15:0];
        rdata_nxt = 32'h0;
        if (reg_rd) begin
            unique case (reg_addr)
                REG_CFG: rdata_nxt = cfg_r;
                REG_PULSE: rdata_nxt = {16'h0000, pval_r};
                REG_CREEP: rdata_nxt = {16'h0000, creep_r};
                REG_LIM_LO: rdata_nxt = {16'h0000, lo_r};
                REG_LIM_HI: rdata_nxt = {16'h0000, hi_r};
                REG_GAIN: rdata_nxt = {16'h0000, gain_r};
                REG_TOTAL: rdata_nxt = tot_r;
                REG_STATUS: rdata_nxt = {27'h0, st_r};
                REG_MASK: rdata_nxt = {27'h0, mask_r};
                REG_STATE: rdata_nxt = {aout_r, 8'h00, ctl_level,
                    supp_r, limit_hit, rev, dosing_r, empty_r, q2_r, q1_r};
                default: rdata_nxt = 32'h0;
            endcase
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            q1_r <= 1'b0;
            q2_r <= 1'b0;
            aout_r <= UA_0;
            rdata_r <= 32'h0;
        end else begin
            q1_r <= q1_nxt;
            q2_r <= q2_nxt;
            aout_r <= aout_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign primary_switch_output = q1_r;
    assign secondary_switch_output = q2_r;
    assign current_loop_output = aout_r;
    assign reg_rdata = rdata_r;
    assign dose_start = dose_r;
    assign offset_capture = offs_r;
    assign creep_disabled = cdis_r;
    assign irq = |(st_r & mask_r);

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    chk_empty_q1: assert property (q1_fn == FN_EMPTY |=>
        q1_r == ($past(empty_r) == $past(q1_pol)))
        else $error("empty indication wrong");
    chk_limit_q1: assert property (q1_fn == FN_LIMIT |=>
        q1_r == ($past(limit_hit) == $past(q1_pol)))
        else $error("limit indication wrong");
    chk_reverse_q1: assert property (q1_fn == FN_REVERSE |=>
        q1_r == ($past(rev) == $past(q1_pol)))
        else $error("reverse indication wrong");
    chk_dosing_q2: assert property (q2_fn == FN_DOSING |=>
        q2_r == ($past(dosing_r) == $past(q2_pol)))
        else $error("dosing indication wrong");
    chk_dose_start: assert property (in_fn == IN_DOSE && ctl_rise |=>
        dose_start ##1 !dose_start)
        else $error("dose start not one pulse");
    chk_offset_edge: assert property (offset_capture |->
        $past(ctl_rise) && $past(in_fn) == IN_OFFSET)
        else $error("offset capture without edge");
    chk_total_clear: assert property (in_fn == IN_CLEAR && ctl_rise |=>
        tot_r == 32'h0)
        else $error("totalizer not cleared");
    chk_creep_off: assert property (creep_dis |=> !supp_r && creep_disabled)
        else $error("creep suppression still on");
    chk_alert_level: assert property (cfg_r[CFG_AOUT_EN] &&
        !cfg_r[CFG_AOUT_0_20] && empty_r |=> aout_r == UA_ALERT)
        else $error("empty alert level missing");

    cov_dose: cover property (in_fn == IN_DOSE && ctl_rise ##1 dose_start);
    cov_alert: cover property (aout_r == UA_ALERT);
    cov_suppress: cover property (!supp_r ##1 supp_r);
    cov_pulse: cover property (q1_fn == FN_PULSE && vpulse);
endmodule // flow_io_top

// ==== dv/far_side.sv ====
// Far side model: controller on the input, pulse counter on the outputs
`timescale 1ns/100ps
module far_side (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Switched outputs watched
    input wire logic primary_switch_output,
    input wire logic secondary_switch_output,
    // Control pin driven
    output logic control_input
);
    int p_cnt;
    int s_cnt;
    logic p_d;
    logic s_d;

    initial control_input = 1'b0;

    // Counts every rise to 24 V, as an external counter would
    always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            p_cnt <= 0;
            s_cnt <= 0;
            p_d <= 1'b0;
            s_d <= 1'b0;
        end else begin
            p_d <= primary_switch_output;
            s_d <= secondary_switch_output;
            if (primary_switch_output && !p_d) p_cnt <= p_cnt + 1;
            if (secondary_switch_output && !s_d) s_cnt <= s_cnt + 1;
        end
    end

    // Level held four cycles so the low gap exceeds two
    task automatic hold(input logic v);
        @(posedge clock);
        control_input <= v;
        repeat (4) @(posedge clock);
    endtask

    task automatic press;
        hold(1'b1);
        hold(1'b0);
    endtask
endmodule // far_side

// ==== dv/tb_top.sv ====
// Self-checking bench for the meter switched outputs and control input
`timescale 1ns/100ps
module tb_top;
    import flow_io_pkg::*;
    logic clock;
    logic resetn;
    logic [AW-1:0] reg_addr;
    logic [DW-1:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [DW-1:0] reg_rdata;
    logic flow_valid;
    logic signed [15:0] flow_rate;
    logic [15:0] vol_inc;
    logic empty_pipe;
    logic dosing_active;
    logic dose_start;
    logic offset_capture;
    logic creep_disabled;
    logic control_input;
    logic primary_switch_output;
    logic secondary_switch_output;
    logic [15:0] current_loop_output;
    logic irq;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    int dose_n = 0;
    int off_n = 0;
    logic [31:0] rv;

    // Short pulse width keeps the run small
    flow_io_top #(.PULSE_CYC(3)) i_flow_io_top (.clock, .resetn,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .flow_valid,
        .flow_rate, .vol_inc, .empty_pipe, .dosing_active, .dose_start,
        .offset_capture, .creep_disabled, .control_input,
        .primary_switch_output, .secondary_switch_output,
        .current_loop_output, .irq);

    far_side i_far_side (.clock, .resetn, .primary_switch_output,
        .secondary_switch_output, .control_input);

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic give_verdict;
        if (error_cnt == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cyc++;
        if (dose_start === 1'b1) dose_n++;
        if (offset_capture === 1'b1) off_n++;
        if (cyc == 5000) begin
            error_cnt++;
            $display("[FAIL] %0t run hung", $time);
            give_verdict;
        end
    end

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic sample(input logic [15:0] r, input logic [15:0] v);
        @(posedge clock);
        flow_valid <= 1'b1;
        flow_rate <= r;
        vol_inc <= v;
        @(posedge clock);
        flow_valid <= 1'b0;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    function automatic logic [31:0] cfg(input logic [2:0] a, input logic ah,
            input logic [2:0] b, input logic bh, input logic [1:0] i);
        return {20'h0, 1'b1, 1'b0, i, bh, b, ah, a};
    endfunction

    function automatic logic [31:0] pins;
        return {30'h0, primary_switch_output, secondary_switch_output};
    endfunction

    task automatic t_regs;
        rd(REG_CFG, rv);
        chk_val(rv, CFG_RESET);
        rd(REG_PULSE, rv);
        chk_val(rv, {16'h0, PULSE_RESET});
        wr(REG_PULSE, 32'h0000_7531);
        rd(REG_PULSE, rv);
        chk_val(rv, {16'h0, PULSE_MAX});
        wr(REG_PULSE, 32'h0);
        rd(REG_PULSE, rv);
        chk_val(rv, {16'h0, PULSE_MIN});
        wr(8'h40, 32'h0000_00FF);
        rd(8'h40, rv);
        chk_val(rv, 32'h0);
        wr(REG_PULSE, {16'h0, PULSE_RESET});
    endtask

    // Suppressed samples must add nothing
    task automatic t_pulse;
        int p0;
        int s0;
        wr(REG_CFG, cfg(FN_PULSE, 1'b1, FN_PULSE, 1'b1, IN_DOSE));
        p0 = i_far_side.p_cnt;
        s0 = i_far_side.s_cnt;
        sample(16'h0064, 16'h0000);
        repeat (3) sample(16'h0064, 16'h000A);
        sample(16'h0002, 16'h0000);
        sample(16'h0004, 16'h000A);
        sample(16'h0005, 16'h0000);
        sample(16'h0005, 16'h000A);
        settle(40);
        chk_val(i_far_side.p_cnt - p0, 32'h4);
        chk_val(i_far_side.s_cnt - s0, 32'h4);
        rd(REG_TOTAL, rv);
        chk_val(rv, 32'h0000_0028);
    endtask

    task automatic t_current;
        sample(16'h0002, 16'h0000);
        settle(3);
        chk_val({16'h0, current_loop_output}, {16'h0, UA_4});
        sample(16'h0064, 16'h0000);
        settle(3);
        chk_val({16'h0, current_loop_output}, 32'h0000_10AA);
        wr(REG_CFG, cfg(FN_OFF, 1'b1, FN_OFF, 1'b1, IN_DOSE) | 32'h400);
        settle(3);
        chk_val({16'h0, current_loop_output}, 32'h0000_010A);
        wr(REG_CFG, cfg(FN_OFF, 1'b1, FN_OFF, 1'b1, IN_DOSE) & 32'hFFFF_F7FF);
        settle(3);
        chk_val({16'h0, current_loop_output}, {16'h0, UA_0});
    endtask

    task automatic t_limit;
        wr(REG_CFG, cfg(FN_LIMIT, 1'b1, FN_LIMIT, 1'b0, IN_DOSE));
        sample(16'h1770, 16'h0000);
        settle(3);
        chk_val(pins(), 32'h2);
        sample(16'h0064, 16'h0000);
        settle(3);
        chk_val(pins(), 32'h1);
        wr(REG_CFG, cfg(FN_REVERSE, 1'b1, FN_DOSING, 1'b1, IN_DOSE));
        sample(16'hFFF6, 16'h0000);
        dosing_active <= 1'b1;
        settle(3);
        chk_val(pins(), 32'h3);
        sample(16'h0064, 16'h0000);
        dosing_active <= 1'b0;
        settle(3);
        chk_val(pins(), 32'h0);
    endtask

    task automatic t_empty;
        wr(REG_CFG, cfg(FN_OFF, 1'b1, FN_EMPTY, 1'b1, IN_DOSE));
        @(posedge clock);
        empty_pipe <= 1'b1;
        settle(3);
        chk_val(pins(), 32'h1);
        chk_val({16'h0, current_loop_output}, {16'h0, UA_ALERT});
        chk_val({31'h0, irq}, 32'h0);
        wr(REG_MASK, 32'h1 << ST_EMPTY);
        settle(1);
        chk_val({31'h0, irq}, 32'h1);
        wr(REG_STATUS, 32'h1 << ST_EMPTY);
        settle(1);
        chk_val({31'h0, irq}, 32'h0);
        wr(REG_CFG, cfg(FN_EMPTY, 1'b1, FN_EMPTY, 1'b0, IN_DOSE));
        settle(3);
        chk_val(pins(), 32'h2);
        @(posedge clock);
        empty_pipe <= 1'b0;
        settle(4);
        chk_val(pins(), 32'h1);
        wr(REG_MASK, 32'h0);
    endtask

    task automatic t_input;
        int p0;
        wr(REG_CFG, cfg(FN_OFF, 1'b1, FN_OFF, 1'b1, IN_DOSE));
        i_far_side.press();
        chk_val(dose_n, 32'h1);
        rd(REG_STATUS, rv);
        chk_val(rv & 32'h1, 32'h1);
        wr(REG_CFG, cfg(FN_OFF, 1'b1, FN_OFF, 1'b1, IN_OFFSET));
        i_far_side.press();
        chk_val({dose_n[15:0], off_n[15:0]}, 32'h0001_0001);
        wr(REG_CFG, cfg(FN_OFF, 1'b1, FN_OFF, 1'b1, IN_CLEAR));
        i_far_side.press();
        rd(REG_TOTAL, rv);
        chk_val(rv, 32'h0);
        sample(16'h0064, 16'h0007);
        settle(4);
        rd(REG_TOTAL, rv);
        chk_val(rv, 32'h7);
        wr(REG_CFG, cfg(FN_PULSE, 1'b1, FN_OFF, 1'b1, IN_CREEP));
        // Low flow first, so suppression is on before the override
        sample(16'h0001, 16'h0000);
        p0 = i_far_side.p_cnt;
        i_far_side.hold(1'b1);
        sample(16'h0001, 16'h000A);
        settle(12);
        chk_val({31'h0, creep_disabled}, 32'h1);
        chk_val(i_far_side.p_cnt - p0, 32'h1);
        i_far_side.hold(1'b0);
        settle(2);
        chk_val({31'h0, creep_disabled}, 32'h0);
        sample(16'h0001, 16'h000A);
        settle(12);
        chk_val(i_far_side.p_cnt - p0, 32'h1);
    endtask

    initial begin
        resetn = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        flow_rate = '0;
        vol_inc = '0;
        {reg_wr, reg_rd, flow_valid, empty_pipe, dosing_active} = '0;
        repeat (4) @(posedge clock);
        resetn <= 1'b1;
        t_regs;
        t_pulse;
        t_current;
        t_limit;
        t_empty;
        t_input;
        give_verdict;
    end
endmodule // tb_top
